/* File: verilog/cam_port_map.vh */
// Purpose: Constants of the sensor video port and timing generator.
// Assumes: Included by the top design file and by the assertion and bench files, bare name.
// Notes: Counts are in pixel periods unless named otherwise.
`ifndef CAM_PORT_MAP_VH
`define CAM_PORT_MAP_VH
// Register offsets
`define OFS_GAIN 8'h00
`define OFS_EXPOSURE 8'h10
`define OFS_PRESCALE 8'h11
`define OFS_MODE 8'h12
`define OFS_CROP_START 8'h17
`define OFS_CROP_STOP 8'h18
`define OFS_DPIX_CTRL 8'h2a
`define OFS_DPIX_LOW 8'h2b
`define OFS_DLINE_LOW 8'h2d
`define OFS_DLINE_HIGH 8'h2e
`define OFS_VPORT 8'h38
`define OFS_STATUS 8'h3f
// Field positions
`define MODE_SUBSAMPLE_BIT 5
`define MODE_RESTART_BIT 6
`define VPORT_SWAP_BIT 0
`define VPORT_SLAVE_BIT 1
`define VPORT_SINGLE_BIT 2
`define VPORT_RISE_BIT 4
`define VPORT_GATE_BIT 5
// Reset values
`define RST_GAIN 8'h00
`define RST_EXPOSURE 8'h00
`define RST_PRESCALE 8'h00
`define RST_MODE 8'h00
`define RST_CROP_START 8'h00
`define RST_CROP_STOP 8'ha0
`define RST_DPIX 8'h00
`define RST_DLINE 8'h00
`define RST_VPORT 8'h00
// Timing counts in pixel periods and lines
`define FULL_LINE_TOTAL 13'd1520
`define SUB_LINE_TOTAL 13'd800
`define FULL_FRAME_TOTAL 17'd1050
`define SUB_FRAME_TOTAL 17'd500
`define FULL_COLS 13'd1280
`define SUB_COLS 13'd640
`define FULL_ROWS 17'd1024
`define SUB_ROWS 17'd480
`define V_ACTIVE_START 17'd8
`define V_SYNC_LINES 17'd4
`define H_SYNC_GAP 13'd16
`define H_SYNC_WIDTH 13'd32
// Color codes on the sample-kind output
`define KIND_BLUE 2'h0
`define KIND_GREEN 2'h1
`define KIND_RED 2'h2
`define KIND_LUMA 2'h3
`endif

/* File: verilog/sync2.v */
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Inputs are slow levels from outside the clock domain.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter WIDTH = 1
) (
	input wire mclk,
	input wire nrst,
	input wire [WIDTH-1:0] din,
	output wire [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] meta_ff;
	reg [WIDTH-1:0] sync_ff;

	// Two flip-flops in a row
	always @(posedge mclk) begin
		if (!nrst) begin
			meta_ff <= {WIDTH{1'b0}};
			sync_ff <= {WIDTH{1'b0}};
		end else begin
			meta_ff <= din;
			sync_ff <= meta_ff;
		end
	end

	assign dout = sync_ff;
endmodule
`default_nettype wire

/* File: verilog/clk_prescale.v */
// Purpose: Half-period strobe generator for the pixel clock.
// Assumes: div is the low six bits of the prescale register.
// Notes: One pixel period lasts 2*(div+1) clock cycles.
`timescale 1ns/1ps
`default_nettype none
module clk_prescale #(
	parameter DW = 6
) (
	input wire mclk,
	input wire nrst,
	input wire [DW-1:0] div,
	input wire restart,
	output wire half_tick,
	output wire phase
);
	reg [DW-1:0] cnt_ff;
	reg phase_ff;
	wire at_end;

	assign at_end = (cnt_ff >= div);
	assign half_tick = at_end;
	assign phase = phase_ff;

	// Count clock cycles per half pixel period
	always @(posedge mclk) begin
		if (!nrst || restart) begin
			cnt_ff <= {DW{1'b0}};
			phase_ff <= 1'b0;
		end else if (at_end) begin
			cnt_ff <= {DW{1'b0}};
			phase_ff <= ~phase_ff;
		end else begin
			cnt_ff <= cnt_ff + {{(DW-1){1'b0}}, 1'b1};
		end
	end
endmodule
`default_nettype wire

/* File: verilog/camera_pixel_port_timing.v */
// Purpose: Video output port and timing generator of an image sensor.
// Assumes: Registers arrive decoded from the serial control port.
// Notes: Pixel samples come from the array at the read address.
`include "cam_port_map.vh"
`timescale 1ns/1ps
`default_nettype none
module camera_pixel_port_timing #(
	parameter MONO = 0,
	parameter DW = 10
) (
	input wire mclk,
	input wire nrst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_we,
	input wire reg_re,
	output reg [7:0] reg_rdata_ff,
	input wire [DW-1:0] pixel_in,
	input wire frame_exposure_enable,
	input wire exposure_start_strobe,
	input wire subsample_pin,
	input wire hsync_in,
	input wire vsync_in,
	output reg hsync_out_ff,
	output reg vsync_out_ff,
	output reg sync_oe_n_ff,
	output reg pclk_ff,
	output reg line_valid_ff,
	output reg [DW-1:0] pix_data_ff,
	output reg [1:0] sample_kind_ff,
	output reg [10:0] read_row_ff,
	output reg [10:0] read_col_ff,
	output reg array_reset_ff,
	output reg exposing_ff
);
	// Exposure sequence states
	localparam ST_LIVE = 3'd0;
	localparam ST_PRE_HOLD = 3'd1;
	localparam ST_PRE_LINE = 3'd2;
	localparam ST_EXPOSE = 3'd3;
	localparam ST_READOUT = 3'd4;
	localparam ST_STOP = 3'd5;

	reg [7:0] gain_ff, exposure_ff, prescale_ff, mode_ff;
	reg [7:0] crop_start_ff, crop_stop_ff, vport_ff;
	reg [7:0] dpix_ctrl_ff, dpix_low_ff, dline_low_ff, dline_high_ff;
	reg [11:0] dpix_sh_ff;
	reg [15:0] dline_sh_ff;
	reg [12:0] h_ff;
	reg [16:0] v_ff;
	reg [12:0] pre_cnt_ff;
	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg restart_pend_ff, zero_pend_ff, hs_pend_ff;
	reg frame_exposure_enable_d_ff, hs_d_ff, vs_d_ff;
	reg [DW-1:0] swapped;
	reg [12:0] cols, line_total, k_lo, k_hi, k;
	reg [16:0] rows, frame_total, r_off, r;
	reg in_cols, in_rows, act, line_end, frame_end;
	integer i;
	wire [4:0] pins_s;
	wire frame_exposure_enable_s, stb_s, sub_s, hs_s, vs_s;
	wire half_tick, phase, data_tick, clk_tick;
	wire sub_mode, slave, gate, rise, video_on;
	wire restart_req, mode_wr, hs_edge, vs_edge, frame_exposure_enable_rise, frame_exposure_enable_fall;

	sync2 #(.WIDTH(5)) u_sync (
		.mclk(mclk),
		.nrst(nrst),
		.din({frame_exposure_enable, exposure_start_strobe, subsample_pin,
			hsync_in, vsync_in}),
		.dout(pins_s)
	);
	assign {frame_exposure_enable_s, stb_s, sub_s, hs_s, vs_s} = pins_s;

	clk_prescale #(.DW(6)) u_presc (
		.mclk(mclk),
		.nrst(nrst),
		.div(prescale_ff[5:0]),
		.restart(1'b0),
		.half_tick(half_tick),
		.phase(phase)
	);
	assign data_tick = half_tick & ~phase;
	assign clk_tick = half_tick & phase;

	assign sub_mode = sub_s | mode_ff[`MODE_SUBSAMPLE_BIT];
	assign slave = vport_ff[`VPORT_SLAVE_BIT];
	assign gate = vport_ff[`VPORT_GATE_BIT];
	assign rise = vport_ff[`VPORT_RISE_BIT];
	assign mode_wr = reg_we && (reg_addr == `OFS_MODE);
	// Set-then-clear of the restart bit, or any prescale write
	assign restart_req = (mode_wr && mode_ff[`MODE_RESTART_BIT] &&
		!reg_wdata[`MODE_RESTART_BIT]) ||
		(reg_we && (reg_addr == `OFS_PRESCALE));
	assign hs_edge = slave && hs_s && !hs_d_ff;
	assign vs_edge = slave && vs_s && !vs_d_ff;
	assign frame_exposure_enable_rise = frame_exposure_enable_s && !frame_exposure_enable_d_ff;
	assign frame_exposure_enable_fall = !frame_exposure_enable_s && frame_exposure_enable_d_ff;
	assign video_on = (nxt_state == ST_LIVE) || (nxt_state == ST_READOUT);

	// Register writes; cropping returns to defaults on a mode write
	always @(posedge mclk) begin
		if (!nrst) begin
			gain_ff <= `RST_GAIN;
			exposure_ff <= `RST_EXPOSURE;
			prescale_ff <= `RST_PRESCALE;
			mode_ff <= `RST_MODE;
			crop_start_ff <= `RST_CROP_START;
			crop_stop_ff <= `RST_CROP_STOP;
			dpix_ctrl_ff <= `RST_DPIX;
			dpix_low_ff <= `RST_DPIX;
			dline_low_ff <= `RST_DLINE;
			dline_high_ff <= `RST_DLINE;
			vport_ff <= `RST_VPORT;
		end else if (reg_we) begin
			case (reg_addr)
			`OFS_GAIN: gain_ff <= reg_wdata;
			`OFS_EXPOSURE: exposure_ff <= reg_wdata;
			`OFS_PRESCALE: prescale_ff <= reg_wdata;
			`OFS_MODE: begin
				mode_ff <= reg_wdata;
				crop_start_ff <= `RST_CROP_START;
				crop_stop_ff <= `RST_CROP_STOP;
			end
			`OFS_CROP_START: crop_start_ff <= reg_wdata;
			`OFS_CROP_STOP: crop_stop_ff <= reg_wdata;
			`OFS_DPIX_CTRL: dpix_ctrl_ff <= reg_wdata;
			`OFS_DPIX_LOW: dpix_low_ff <= reg_wdata;
			`OFS_DLINE_LOW: dline_low_ff <= reg_wdata;
			`OFS_DLINE_HIGH: dline_high_ff <= reg_wdata;
			`OFS_VPORT: vport_ff <= reg_wdata;
			default: ;
			endcase
		end
	end

	// Registered read data, unmapped addresses read zero
	always @(posedge mclk) begin
		if (!nrst) begin
			reg_rdata_ff <= 8'h00;
		end else if (reg_re) begin
			case (reg_addr)
			`OFS_GAIN: reg_rdata_ff <= gain_ff;
			`OFS_EXPOSURE: reg_rdata_ff <= exposure_ff;
			`OFS_PRESCALE: reg_rdata_ff <= prescale_ff;
			`OFS_MODE: reg_rdata_ff <= mode_ff;
			`OFS_CROP_START: reg_rdata_ff <= crop_start_ff;
			`OFS_CROP_STOP: reg_rdata_ff <= crop_stop_ff;
			`OFS_DPIX_CTRL: reg_rdata_ff <= dpix_ctrl_ff;
			`OFS_DPIX_LOW: reg_rdata_ff <= dpix_low_ff;
			`OFS_DLINE_LOW: reg_rdata_ff <= dline_low_ff;
			`OFS_DLINE_HIGH: reg_rdata_ff <= dline_high_ff;
			`OFS_VPORT: reg_rdata_ff <= vport_ff;
			`OFS_STATUS: reg_rdata_ff <= {restart_pend_ff, exposing_ff,
				array_reset_ff, line_valid_ff, vsync_out_ff, state_ff};
			default: reg_rdata_ff <= 8'h00;
			endcase
		end
	end

	// Line and frame geometry of the current mode
	always @* begin
		cols = sub_mode ? `SUB_COLS : `FULL_COLS;
		rows = sub_mode ? `SUB_ROWS : `FULL_ROWS;
		line_total = (sub_mode ? `SUB_LINE_TOTAL : `FULL_LINE_TOTAL) +
			{1'b0, dpix_sh_ff};
		frame_total = (sub_mode ? `SUB_FRAME_TOTAL : `FULL_FRAME_TOTAL) +
			{1'b0, dline_sh_ff};
		k = h_ff;
		r_off = v_ff - `V_ACTIVE_START;
		r = r_off;
		k_lo = {2'b00, crop_start_ff, 3'b000};
		k_hi = {2'b00, crop_stop_ff, 3'b000};
		in_cols = (k < cols) && (k >= k_lo) && (k < k_hi);
		in_rows = (v_ff >= `V_ACTIVE_START) && (r < rows);
		act = in_cols && in_rows && video_on;
		line_end = (h_ff >= line_total - 13'd1);
		frame_end = line_end && (v_ff >= frame_total - 17'd1);
		for (i = 0; i < DW; i = i + 1) begin
			swapped[i] = pixel_in[DW-1-i];
		end
	end

	// Pending restart and slave trigger flags; a new set wins
	always @(posedge mclk) begin
		if (!nrst) begin
			restart_pend_ff <= 1'b0;
			zero_pend_ff <= 1'b0;
			hs_pend_ff <= 1'b0;
			frame_exposure_enable_d_ff <= 1'b0;
			hs_d_ff <= 1'b0;
			vs_d_ff <= 1'b0;
		end else begin
			frame_exposure_enable_d_ff <= frame_exposure_enable_s;
			hs_d_ff <= hs_s;
			vs_d_ff <= vs_s;
			restart_pend_ff <= restart_req ||
				(restart_pend_ff && !(data_tick && line_end));
			zero_pend_ff <= vs_edge ||
				(frame_exposure_enable_fall && state_ff == ST_EXPOSE) ||
				(zero_pend_ff && !data_tick);
			hs_pend_ff <= hs_edge || (hs_pend_ff && !data_tick);
		end
	end

	// Horizontal counter advances once per pixel period, vertical counter once per line
	always @(posedge mclk) begin
		if (!nrst) begin
			h_ff <= 13'd0;
			v_ff <= 17'd0;
			dpix_sh_ff <= 12'd0;
			dline_sh_ff <= 16'd0;
		end else if (data_tick) begin
			if (zero_pend_ff || (restart_pend_ff && line_end)) begin
				h_ff <= 13'd0;
				v_ff <= 17'd0;
				dpix_sh_ff <= {dpix_ctrl_ff[7:4], dpix_low_ff};
				dline_sh_ff <= {dline_high_ff, dline_low_ff};
			end else if (hs_pend_ff || line_end) begin
				h_ff <= 13'd0;
				v_ff <= frame_end ? 17'd0 : v_ff + 17'd1;
			end else begin
				h_ff <= h_ff + 13'd1;
			end
		end
	end

	// Exposure sequence
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
		ST_LIVE, ST_STOP: begin
			if (frame_exposure_enable_rise && stb_s) begin
				nxt_state = ST_PRE_HOLD;
			end else if (frame_exposure_enable_rise) begin
				nxt_state = ST_PRE_LINE;
			end
		end
		ST_PRE_HOLD: begin
			if (!frame_exposure_enable_s) begin
				nxt_state = ST_LIVE;
			end else if (!stb_s) begin
				nxt_state = ST_EXPOSE;
			end
		end
		ST_PRE_LINE: begin
			if (!frame_exposure_enable_s) begin
				nxt_state = ST_LIVE;
			end else if (data_tick && pre_cnt_ff >= line_total - 13'd1) begin
				nxt_state = ST_EXPOSE;
			end
		end
		ST_EXPOSE: begin
			if (!frame_exposure_enable_s) begin
				nxt_state = ST_READOUT;
			end
		end
		ST_READOUT: begin
			if (data_tick && frame_end && !zero_pend_ff) begin
				nxt_state = vport_ff[`VPORT_SINGLE_BIT] ?
					ST_STOP : ST_LIVE;
			end
		end
		default: nxt_state = ST_LIVE;
		endcase
	end

	// State register and pre-charge line counter
	always @(posedge mclk) begin
		if (!nrst) begin
			state_ff <= ST_LIVE;
			pre_cnt_ff <= 13'd0;
			array_reset_ff <= 1'b0;
			exposing_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			if (nxt_state != ST_PRE_LINE) begin
				pre_cnt_ff <= 13'd0;
			end else if (data_tick && state_ff == ST_PRE_LINE) begin
				pre_cnt_ff <= pre_cnt_ff + 13'd1;
			end
			array_reset_ff <= (nxt_state == ST_PRE_HOLD) ||
				(nxt_state == ST_PRE_LINE);
			exposing_ff <= (nxt_state == ST_EXPOSE);
		end
	end

	// Pixel word, qualifiers and read address change with the data phase
	always @(posedge mclk) begin
		if (!nrst) begin
			pix_data_ff <= {DW{1'b0}};
			line_valid_ff <= 1'b0;
			sample_kind_ff <= `KIND_BLUE;
			read_row_ff <= 11'd0;
			read_col_ff <= 11'd0;
			hsync_out_ff <= 1'b0;
			vsync_out_ff <= 1'b0;
			sync_oe_n_ff <= 1'b0;
		end else begin
			sync_oe_n_ff <= slave;
			if (data_tick) begin
				line_valid_ff <= act;
				pix_data_ff <= !act ? {DW{1'b0}} :
					(vport_ff[`VPORT_SWAP_BIT] ? swapped : pixel_in);
				read_col_ff <= sub_mode ? {k[9:1], 1'b0, k[0]} : k[10:0];
				read_row_ff <= sub_mode ? {r[9:1], 1'b0, r[0]} : r[10:0];
				if (MONO != 0) begin
					sample_kind_ff <= `KIND_LUMA;
				end else if (!r[0]) begin
					sample_kind_ff <= k[0] ? `KIND_GREEN : `KIND_BLUE;
				end else begin
					sample_kind_ff <= k[0] ? `KIND_RED : `KIND_GREEN;
				end
				hsync_out_ff <= !slave && (k >= cols + `H_SYNC_GAP) &&
					(k < cols + `H_SYNC_GAP + `H_SYNC_WIDTH);
				vsync_out_ff <= !slave && (v_ff < `V_SYNC_LINES);
			end else if (!video_on) begin // Blank at once when video stops
				line_valid_ff <= 1'b0;
				pix_data_ff <= {DW{1'b0}};
			end
		end
	end

	// Pixel clock: data changes on one edge and is stable for the other
	always @(posedge mclk) begin
		if (!nrst) begin
			pclk_ff <= 1'b0;
		end else if (data_tick) begin
			if (gate && !act) begin
				pclk_ff <= rise;
			end else begin
				pclk_ff <= ~rise;
			end
		end else if (clk_tick) begin // Gated clock already rests here
			pclk_ff <= rise;
		end
	end
endmodule
`default_nettype wire

/* File: tb/cam_port_assertions.sv */
// Purpose: Port assertions for the pixel port and timing block.
// Assumes: Register writes are visible on the decoded strobe ports.
// Notes: Video control and prescale are shadowed from those writes.
`include "cam_port_map.vh"
`timescale 1ns/1ps
`default_nettype none
module cam_port_assertions #(
	parameter DW = 10
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	input wire logic [7:0] reg_rdata_ff,
	input wire logic hsync_out_ff,
	input wire logic sync_oe_n_ff,
	input wire logic pclk_ff,
	input wire logic line_valid_ff,
	input wire logic [DW-1:0] pix_data_ff,
	input wire logic [1:0] sample_kind_ff,
	input wire logic [10:0] read_row_ff,
	input wire logic [10:0] read_col_ff,
	input wire logic array_reset_ff,
	input wire logic exposing_ff
);
	logic [7:0] vport_ff;
	logic [7:0] pre_ff;
	logic [3:0] age_ff;
	logic mapped;
	logic settled;
	logic [1:0] bayer;
	// Decoded map, settle time, and expected colour of the current word
	assign mapped = reg_addr inside {`OFS_GAIN, `OFS_EXPOSURE, `OFS_PRESCALE,
		`OFS_MODE, `OFS_CROP_START, `OFS_CROP_STOP, `OFS_DPIX_CTRL,
		`OFS_DPIX_LOW, `OFS_DLINE_LOW, `OFS_DLINE_HIGH, `OFS_VPORT,
		`OFS_STATUS};
	assign settled = age_ff[3];
	assign bayer = read_row_ff[0] ? (read_col_ff[0] ? `KIND_RED : `KIND_GREEN)
		: (read_col_ff[0] ? `KIND_GREEN : `KIND_BLUE);
	// Shadow control writes; age blocks checks just after a change
	always @(posedge mclk) begin
		if (!nrst) begin
			vport_ff <= 8'h00;
			pre_ff <= 8'h00;
			age_ff <= 4'h0;
		end else if (reg_we && (reg_addr == `OFS_VPORT ||
			reg_addr == `OFS_PRESCALE)) begin
			vport_ff <= (reg_addr == `OFS_VPORT) ? reg_wdata : vport_ff;
			pre_ff <= (reg_addr == `OFS_PRESCALE) ? reg_wdata : pre_ff;
			age_ff <= 4'h0;
		end else if (age_ff != 4'hf) begin
			age_ff <= age_ff + 4'h1;
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	chk_unmapped_read: assert property (reg_re && !mapped |=>
		reg_rdata_ff == 8'h00)
		else $error("unmapped read gave nonzero data");
	chk_rdata_hold: assert property (!reg_re |=> $stable(reg_rdata_ff))
		else $error("read data moved without a read");
	chk_blank_data: assert property (!line_valid_ff |-> pix_data_ff == '0)
		else $error("pixel bus not blank outside line valid");
	chk_gate_hold: assert property (settled && vport_ff[5] &&
		!line_valid_ff && $past(!line_valid_ff) |-> pclk_ff == vport_ff[4])
		else $error("gated pixel clock moved outside line valid");
	chk_launch_edge: assert property (settled && !vport_ff[5] &&
		$rose(line_valid_ff) |-> pclk_ff != vport_ff[4])
		else $error("first word not launched on the idle edge");
	chk_pclk_rate: assert property (settled && pre_ff[5:0] == 6'h00 &&
		line_valid_ff && $past(line_valid_ff) |-> pclk_ff != $past(pclk_ff))
		else $error("pixel clock not at half the input rate");
	chk_bayer_kind: assert property (line_valid_ff |->
		sample_kind_ff == bayer)
		else $error("colour order wrong for row and column");
	chk_sync_drive: assert property (settled |-> sync_oe_n_ff == vport_ff[1] &&
		!(vport_ff[1] && hsync_out_ff))
		else $error("sync pin direction wrong for port mode");
	chk_dark_exposure: assert property (array_reset_ff || exposing_ff |->
		!line_valid_ff)
		else $error("video output during pre-charge or exposure");
	cover property ($rose(line_valid_ff));
	cover property ($rose(array_reset_ff));
	cover property ($rose(exposing_ff));
endmodule
bind camera_pixel_port_timing cam_port_assertions #(.DW(DW))
	cam_port_assertions_inst (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
	.reg_rdata_ff(reg_rdata_ff), .hsync_out_ff(hsync_out_ff),
	.sync_oe_n_ff(sync_oe_n_ff), .pclk_ff(pclk_ff),
	.line_valid_ff(line_valid_ff), .pix_data_ff(pix_data_ff),
	.sample_kind_ff(sample_kind_ff), .read_row_ff(read_row_ff),
	.read_col_ff(read_col_ff), .array_reset_ff(array_reset_ff),
	.exposing_ff(exposing_ff));
`default_nettype wire

/* File: tb/capture_model.sv */
// Purpose: Capture logic on the far side of the pixel port.
// Assumes: rise_sel follows the chosen sampling edge.
// Notes: Counts words of each line, keeps the last one.
`timescale 1ns/1ps
`default_nettype none
module capture_model (
	input wire logic pclk_ff,
	input wire logic line_valid_ff,
	input wire logic [9:0] pix_data_ff,
	input wire logic rise_sel,
	output logic [11:0] line_words,
	output logic [9:0] last_word
);
	logic [11:0] cnt;
	initial begin
		cnt = 12'h000;
		line_words = 12'h000;
		last_word = 10'h000;
	end
	// Store a word only on the chosen edge inside line valid
	always @(pclk_ff) begin
		if (line_valid_ff && pclk_ff == rise_sel) begin
			cnt <= cnt + 12'h001;
			last_word <= pix_data_ff;
		end
	end
	// Close the line count when line valid drops
	always @(negedge line_valid_ff) begin
		line_words <= cnt;
		cnt <= 12'h000;
	end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the pixel port and timing block.
// Assumes: Reduced resolution pin held high to keep lines short.
// Notes: Inputs change on the falling clock edge.
`include "cam_port_map.vh"
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic mclk, nrst, reg_we, reg_re, rise_sel;
	logic frame_exposure_enable, exposure_start_strobe;
	logic subsample_pin, hsync_in, vsync_in;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, q;
	logic [9:0] pixel_in, pix_data_ff, last_word;
	logic hsync_out_ff, vsync_out_ff, sync_oe_n_ff, pclk_ff;
	logic line_valid_ff, array_reset_ff, exposing_ff;
	logic [1:0] sample_kind_ff;
	logic [10:0] read_row_ff, read_col_ff;
	logic [11:0] line_words;
	int error_cnt, samples_checked, n, m;
	// Rows: address, write flag, write data, expected read
	logic [24:0] rows [0:21] = '{
		{8'h00, 1'b0, 8'h00, 8'h00}, {8'h10, 1'b0, 8'h00, 8'h00},
		{8'h11, 1'b0, 8'h00, 8'h00}, {8'h12, 1'b0, 8'h00, 8'h00},
		{8'h17, 1'b0, 8'h00, 8'h00}, {8'h18, 1'b0, 8'h00, 8'ha0},
		{8'h2a, 1'b0, 8'h00, 8'h00}, {8'h2b, 1'b0, 8'h00, 8'h00},
		{8'h2d, 1'b0, 8'h00, 8'h00}, {8'h2e, 1'b0, 8'h00, 8'h00},
		{8'h38, 1'b0, 8'h00, 8'h00}, {8'h05, 1'b1, 8'h77, 8'h00},
		{8'h10, 1'b1, 8'hff, 8'hff}, {8'h00, 1'b1, 8'h10, 8'h10},
		{8'h17, 1'b1, 8'h03, 8'h03}, {8'h12, 1'b1, 8'h00, 8'h00},
		{8'h17, 1'b0, 8'h00, 8'h00}, {8'h2e, 1'b1, 8'h5a, 8'h5a},
		{8'h2e, 1'b1, 8'h00, 8'h00}, {8'h38, 1'b1, 8'h02, 8'h02},
		{8'h38, 1'b0, 8'h00, 8'h02}, {8'h38, 1'b1, 8'h00, 8'h00}};
	camera_pixel_port_timing camera_pixel_port_timing_inst (.mclk(mclk),
		.nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata_ff(reg_rdata_ff),
		.pixel_in(pixel_in), .frame_exposure_enable(frame_exposure_enable),
		.exposure_start_strobe(exposure_start_strobe),
		.subsample_pin(subsample_pin), .hsync_in(hsync_in),
		.vsync_in(vsync_in), .hsync_out_ff(hsync_out_ff),
		.vsync_out_ff(vsync_out_ff), .sync_oe_n_ff(sync_oe_n_ff),
		.pclk_ff(pclk_ff), .line_valid_ff(line_valid_ff),
		.pix_data_ff(pix_data_ff), .sample_kind_ff(sample_kind_ff),
		.read_row_ff(read_row_ff), .read_col_ff(read_col_ff),
		.array_reset_ff(array_reset_ff), .exposing_ff(exposing_ff));
	capture_model capture_model_inst (.pclk_ff(pclk_ff),
		.line_valid_ff(line_valid_ff), .pix_data_ff(pix_data_ff),
		.rise_sel(rise_sel), .line_words(line_words),
		.last_word(last_word));
	// Free-running input clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic end_sim();
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic cmp_val(input string nm, input logic [15:0] e, g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: pick = line_valid_ff;
			1: pick = array_reset_ff;
			default: pick = exposing_ff;
		endcase
	endfunction
	// Wait for a flag level, return the cycles spent
	task automatic wait_sig(input int s, input logic v, output int c);
		c = 0;
		while (pick(s) !== v && c < 40000) begin
			@(negedge mclk);
			c++;
		end
		if (c >= 40000) begin
			error_cnt++;
			$display("CHECK FAILED wait %0d for %b", s, v);
			end_sim();
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_we = 1'b1;
		@(negedge mclk);
		reg_we = 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] r);
		@(negedge mclk);
		reg_addr = a;
		reg_re = 1'b1;
		@(negedge mclk);
		reg_re = 1'b0;
		@(negedge mclk);
		r = reg_rdata_ff;
	endtask
	// Main sequence
	initial begin
		{nrst, reg_we, reg_re, rise_sel, hsync_in, vsync_in} = 6'h00;
		{frame_exposure_enable, exposure_start_strobe} = 2'h0;
		{reg_addr, reg_wdata, error_cnt, samples_checked} = '0;
		subsample_pin = 1'b1;
		pixel_in = 10'h2c5;
		repeat (16) @(negedge mclk);
		nrst = 1'b1;
		for (int i = 0; i < 22; i++) begin
			if (rows[i][16]) begin
				reg_wr(rows[i][24:17], rows[i][15:8]);
			end
			reg_rd(rows[i][24:17], q);
			cmp_val("register", rows[i][7:0], q);
		end
		reg_wr(`OFS_CROP_STOP, 8'h50);
		reg_rd(`OFS_CROP_STOP, q);
		cmp_val("crop after mode", 16'h0050, q);
		wait_sig(0, 1'b1, n);
		cmp_val("first column", 16'h0000, read_col_ff);
		cmp_val("first kind", `KIND_BLUE, sample_kind_ff);
		cmp_val("pixel word", 10'h2c5, pix_data_ff);
		wait_sig(0, 1'b0, n);
		cmp_val("line words", 16'd640, line_words);
		reg_wr(`OFS_VPORT, 8'h01);
		wait_sig(0, 1'b1, n);
		cmp_val("swapped word", 10'h28d, pix_data_ff);
		wait_sig(0, 1'b0, n);
		reg_wr(`OFS_VPORT, 8'h30);
		rise_sel = 1'b1;
		wait_sig(0, 1'b1, n);
		wait_sig(0, 1'b0, n);
		cmp_val("gated words", 16'd640, line_words);
		cmp_val("gated last", 10'h2c5, last_word);
		reg_wr(`OFS_VPORT, 8'h00);
		rise_sel = 1'b0;
		reg_wr(`OFS_DPIX_LOW, 8'h10);
		reg_wr(`OFS_PRESCALE, 8'h00);
		wait_sig(0, 1'b1, n);
		wait_sig(0, 1'b0, n);
		wait_sig(0, 1'b1, m);
		cmp_val("line period", 16'd1632, 16'(n + m));
		wait_sig(0, 1'b0, n);
		frame_exposure_enable = 1'b1;
		exposure_start_strobe = 1'b1;
		wait_sig(1, 1'b1, n);
		repeat (50) @(negedge mclk);
		cmp_val("held reset", 2'b10, {array_reset_ff, exposing_ff});
		exposure_start_strobe = 1'b0;
		wait_sig(2, 1'b1, n);
		cmp_val("strobe delay", 1'b1, n < 8);
		cmp_val("array free", 1'b0, array_reset_ff);
		frame_exposure_enable = 1'b0;
		wait_sig(2, 1'b0, n);
		wait_sig(0, 1'b1, n);
		cmp_val("readout row", 16'h0000, read_row_ff);
		nrst = 1'b0;
		repeat (16) @(negedge mclk);
		cmp_val("reset outputs", 16'h0000, {line_valid_ff,
			array_reset_ff, exposing_ff, sync_oe_n_ff});
		nrst = 1'b1;
		reg_wr(`OFS_EXPOSURE, 8'hff);
		cmp_val("frame sync", 16'h0001, vsync_out_ff);
		frame_exposure_enable = 1'b1;
		wait_sig(1, 1'b1, n);
		wait_sig(1, 1'b0, n);
		cmp_val("pre-charge", 16'd1600, 16'(n));
		cmp_val("exposing", 1'b1, exposing_ff);
		frame_exposure_enable = 1'b0;
		end_sim();
	end
endmodule
`default_nettype wire
